/* core/prot_switch.sv */
// 1+1 trail protection switch with bridge, selector and protection trail termination.
// Assumes pins of both paths come from outside the clock domain; the link clocks are sampled.
//
// What this block does
// R1: Normal output carries working or protection signal, never a mix.
// R2: Selection follows fail of each path, working degrade, protection degrade under manual 1 only, plus external commands.
// R3: Normal input is bridged permanently to the working output.
// R4: Normal input is bridged permanently to the protection output as well.
// R5: Operation type change while idle leaves traffic undisturbed.
// R6: New restore and hold-off times while idle leave traffic undisturbed.
// R7: Revertive mode waits the restore interval before returning to working.
// R8: Programmable hold-off of 0 to 10 s in 100 ms steps.
// R9: Server signal fail of a path is its fail switching condition.
// R10: Server signal degrade of a path is its degrade switching condition.
// R11: Revertive mode accepts only barred, force 1, manual 1 and clear.
// R12: Uni-directional non-revertive accepts barred, force or manual 0/1, clear.
// R13: Bi-directional non-revertive also accepts trial 0/1 and barred-or-force.
// R14: Bi-directional ends exchange active requests; far-end barred selects working, far-end degrade, fail or force selects protection.
// R15: Termination source passes data, clock and frame start unchanged.
// R16: Termination sink passes traffic up and reports protected trail state.
// R17: Trail fail output follows the incoming server signal fail.
// R18: Fail report cause needs server fail and the report enable.
// R19: Switch completes within 50 ms once hold-off has expired.
// R20: Fail and degrade rank high; protection path carries no extra traffic.
`timescale 1ns/10ps
module prot_switch #(
    parameter int unsigned HOLD_STEP_CYC = prot_switch_pkg::HOLD_STEP_CYCLES,
    parameter int unsigned MINUTE_CYC = prot_switch_pkg::MINUTE_CYCLES
) (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    // Working connection point in
    input wire logic [prot_switch_pkg::DATA_W-1:0] i_work_data,
    input wire logic i_work_clk,
    input wire logic i_work_fs,
    input wire logic i_work_server_signal_fail,
    input wire logic i_work_server_signal_degrade,
    // Protection connection point in
    input wire logic [prot_switch_pkg::DATA_W-1:0] i_prot_data,
    input wire logic i_prot_clk,
    input wire logic i_prot_fs,
    input wire logic i_prot_server_signal_fail,
    input wire logic i_prot_server_signal_degrade,
    input wire logic [3:0] i_switch_protocol_channel,
    // Normal connection point in
    input wire logic [prot_switch_pkg::DATA_W-1:0] i_norm_data,
    input wire logic i_norm_clk,
    input wire logic i_norm_fs,
    // Management
    input wire logic i_bidirectional,
    input wire logic i_operation_type,
    input wire logic [3:0] i_restore_wait_time,
    input wire logic [6:0] i_switch_delay_time,
    input wire logic [3:0] i_external_command,
    input wire logic i_external_command_valid,
    input wire logic i_fail_report_enable,
    // Working and protection outputs
    output logic [prot_switch_pkg::DATA_W-1:0] o_work_data,
    output logic o_work_clk,
    output logic o_work_fs,
    output logic [prot_switch_pkg::DATA_W-1:0] o_prot_data,
    output logic o_prot_clk,
    output logic o_prot_fs,
    output logic [3:0] o_switch_protocol_channel,
    // Normal output towards the layer above
    output logic [prot_switch_pkg::DATA_W-1:0] o_norm_data,
    output logic o_norm_clk,
    output logic o_norm_fs,
    output logic o_trail_fail_out,
    output logic o_fail_report_cause,
    // Status
    output logic o_select_prot,
    output logic o_switch_busy,
    output logic [3:0] o_active_request,
    output logic o_command_refused
);

    typedef struct packed {
        logic [1:0][14:0] ws;
        logic [1:0][14:0] ps;
        logic [1:0][11:0] ns;
        logic [1:0][3:0] aps_s;
        logic [1:0] wsf_s, wsd_s, psf_s, psd_s;
        logic [14:0] wq, pq;
        logic [11:0] nq;
        logic [3:0] cmd;
        logic oper;
        logic [3:0] wtr_min;
        logic [6:0] hold_steps;
        logic [31:0] tick;
        logic [31:0] minute;
        logic [6:0] hold_cnt;
        logic hold_run;
        logic [3:0] wtr_cnt;
        logic wtr_run;
        logic sel;
        logic [3:0] req;
        logic refused;
    } state_t;

    state_t r, next_r;

    function automatic logic cmd_ok(input logic [3:0] c, input logic oper, input logic bidir);
        logic ok;
        ok = 1'b0;
        if (oper == prot_switch_pkg::OPER_REVERT) begin
            ok = c inside {prot_switch_pkg::CMD_CLEAR, prot_switch_pkg::CMD_BARRED,
                           prot_switch_pkg::CMD_FORCE1, prot_switch_pkg::CMD_MANUAL1}; // [R11]
        end else begin
            ok = c inside {prot_switch_pkg::CMD_CLEAR, prot_switch_pkg::CMD_BARRED,
                           prot_switch_pkg::CMD_FORCE0, prot_switch_pkg::CMD_FORCE1,
                           prot_switch_pkg::CMD_MANUAL0, prot_switch_pkg::CMD_MANUAL1}; // [R12]
            if (bidir) begin
                ok = ok || c inside {prot_switch_pkg::CMD_TRIAL0, prot_switch_pkg::CMD_TRIAL1,
                                     prot_switch_pkg::CMD_BARRED_OR_FORCE}; // [R13]
            end
        end
        return ok;
    endfunction : cmd_ok

    always_comb begin
        logic wsf, wsd, psf, psd, fault, want, busy, hold_done;
        logic [3:0] peer;
        next_r = r;
        // Two-stage sampling of path, normal, protocol channel, bidirectional and operation type inputs.
        next_r.ws = {r.ws[0], {i_work_data, i_work_clk, i_work_fs, i_work_server_signal_fail,
                     i_work_server_signal_degrade, 3'b000}};
        next_r.ps = {r.ps[0], {i_prot_data, i_prot_clk, i_prot_fs, i_prot_server_signal_fail,
                     i_prot_server_signal_degrade, 3'b000}};
        next_r.ns = {r.ns[0], {i_norm_data, i_norm_clk, i_norm_fs, i_bidirectional, i_operation_type}};
        next_r.aps_s = {r.aps_s[0], i_switch_protocol_channel};
        wsf = r.ws[1][4]; // [R9]
        wsd = r.ws[1][3]; // [R10]
        psf = r.ps[1][4]; // [R9]
        psd = r.ps[1][3]; // [R10]
        peer = r.aps_s[1];
        next_r.wq = r.ws[1];
        next_r.pq = r.ps[1];
        next_r.nq = r.ns[1];
        busy = (r.req != prot_switch_pkg::REQ_NONE) || r.hold_run || r.wtr_run;
        // Operation type, restore and hold-off times are taken only while no switching is active or pending.
        if (!busy) begin
            next_r.oper = r.ns[1][0]; // [R5]
            next_r.wtr_min = i_restore_wait_time; // [R6]
            next_r.hold_steps = (i_switch_delay_time > prot_switch_pkg::HOLD_MAX_STEPS) ?
                prot_switch_pkg::HOLD_MAX_STEPS : i_switch_delay_time; // [R6] [R8]
        end
        next_r.refused = 1'b0;
        if (i_external_command_valid) begin
            if (cmd_ok(i_external_command, r.oper, r.ns[1][1])) begin
                next_r.cmd = (i_external_command == prot_switch_pkg::CMD_CLEAR) ?
                    prot_switch_pkg::CMD_NONE : i_external_command;
            end else begin
                next_r.refused = 1'b1;
            end
        end
        // Hold-off timer on a new working fault.
        fault = wsf || wsd;
        next_r.tick = (r.tick >= HOLD_STEP_CYC - 1) ? 32'h0 : r.tick + 32'h1;
        if (!fault) begin
            next_r.hold_run = 1'b0;
            next_r.hold_cnt = 7'h0;
        end else if (r.req < prot_switch_pkg::REQ_DEGRADE && !r.hold_run && r.hold_cnt == 7'h0) begin
            next_r.hold_run = (r.hold_steps != 7'h0); // [R8]
        end else if (r.hold_run && r.tick == 32'h0) begin
            next_r.hold_cnt = r.hold_cnt + 7'h1;
            if (r.hold_cnt + 7'h1 >= r.hold_steps) begin
                next_r.hold_run = 1'b0;
            end
        end
        // A working fault is acted on only once its hold-off has fully run out; protection fail is acted on at once.
        hold_done = !r.hold_run && (r.hold_cnt >= r.hold_steps); // [R8]
        // Priority resolution; fail and degrade outrank manual and trial.
        want = r.sel;
        next_r.req = prot_switch_pkg::REQ_NONE;
        if (r.cmd == prot_switch_pkg::CMD_BARRED || (r.ns[1][1] && peer == prot_switch_pkg::REQ_BARRED)) begin
            want = 1'b0;
            next_r.req = prot_switch_pkg::REQ_BARRED;
        end else if (r.cmd inside {prot_switch_pkg::CMD_FORCE0, prot_switch_pkg::CMD_FORCE1,
                                   prot_switch_pkg::CMD_BARRED_OR_FORCE}) begin
            want = (r.cmd != prot_switch_pkg::CMD_FORCE0) && !psf;
            next_r.req = prot_switch_pkg::REQ_FORCE;
        end else if (psf) begin
            want = 1'b0;
            next_r.req = prot_switch_pkg::REQ_FAIL;
        end else if (fault && hold_done) begin
            want = 1'b1; // [R2] [R20]
            next_r.req = wsf ? prot_switch_pkg::REQ_FAIL : prot_switch_pkg::REQ_DEGRADE;
        end else if (r.ns[1][1] && peer >= prot_switch_pkg::REQ_DEGRADE) begin
            want = 1'b1; // [R14]
            next_r.req = peer;
        end else if (r.cmd inside {prot_switch_pkg::CMD_MANUAL0, prot_switch_pkg::CMD_MANUAL1}) begin
            want = (r.cmd == prot_switch_pkg::CMD_MANUAL1) && !psd;
            next_r.req = prot_switch_pkg::REQ_MANUAL;
        end else if (r.cmd inside {prot_switch_pkg::CMD_TRIAL0, prot_switch_pkg::CMD_TRIAL1}) begin
            next_r.req = prot_switch_pkg::REQ_TRIAL; // trial keeps traffic where it is
        end else if (r.sel && r.oper == prot_switch_pkg::OPER_REVERT && !fault) begin
            next_r.req = prot_switch_pkg::REQ_RESTORE;
            if (!r.wtr_run) begin
                next_r.wtr_run = 1'b1;
                next_r.wtr_cnt = 4'h0;
            end else if (next_r.tick == 32'h0 && r.tick == 32'h0) begin
                next_r.wtr_run = 1'b1;
            end
        end
        // Restore wait counted up in minutes, scaled by the minute prescaler.
        if (r.wtr_run && r.req == prot_switch_pkg::REQ_RESTORE) begin
            if (r.minute >= MINUTE_CYC - 1) begin
                next_r.minute = 32'h0;
                next_r.wtr_cnt = r.wtr_cnt + 4'h1; // [R7]
            end else begin
                next_r.minute = r.minute + 32'h1;
            end
        end else begin
            next_r.minute = 32'h0;
        end
        if (next_r.req != prot_switch_pkg::REQ_RESTORE) begin
            next_r.wtr_run = 1'b0;
            next_r.wtr_cnt = 4'h0;
        end
        if (r.wtr_run && r.req == prot_switch_pkg::REQ_RESTORE) begin
            if (r.wtr_cnt >= r.wtr_min) begin
                want = 1'b0; // [R7]
                next_r.wtr_run = 1'b0;
                next_r.req = prot_switch_pkg::REQ_NONE;
            end
        end
        next_r.sel = want; // [R19]
        if (next_r.req == prot_switch_pkg::REQ_NONE && !r.wtr_run) begin
            next_r.sel = (r.oper == prot_switch_pkg::OPER_REVERT) ? 1'b0 : want;
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            r <= '0;
            r.wtr_min <= prot_switch_pkg::RESTORE_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Bridge: both outputs always carry the normal input; no extra traffic on protection.
    assign o_work_data = r.nq[11:4]; // [R3]
    assign o_work_clk = r.nq[3];
    assign o_work_fs = r.nq[2];
    assign o_prot_data = r.nq[11:4]; // [R4] [R15] [R20]
    assign o_prot_clk = r.nq[3];
    assign o_prot_fs = r.nq[2];
    assign o_switch_protocol_channel = r.req; // [R14]
    // Selector: whole-signal choice, never mixed.
    assign o_norm_data = r.sel ? r.pq[14:7] : r.wq[14:7]; // [R1] [R16]
    assign o_norm_clk = r.sel ? r.pq[6] : r.wq[6];
    assign o_norm_fs = r.sel ? r.pq[5] : r.wq[5];
    assign o_trail_fail_out = r.sel ? r.pq[4] : r.wq[4]; // [R17]
    assign o_fail_report_cause = o_trail_fail_out && i_fail_report_enable; // [R18]
    assign o_select_prot = r.sel;
    assign o_switch_busy = (r.req != prot_switch_pkg::REQ_NONE) || r.hold_run || r.wtr_run;
    assign o_active_request = r.req;
    assign o_command_refused = r.refused;

endmodule : prot_switch

/* core/prot_switch_pkg.sv */
// Package of constants and types for the 1+1 trail protection switch.
// Assumes a 100 MHz system clock; long counts are scaled through parameters of the top.
package prot_switch_pkg;
    // System clock rate.
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    // Hold-off step and ceiling.
    localparam int unsigned HOLD_STEP_MS = 100;
    localparam int unsigned HOLD_MAX_S = 10;
    localparam logic [6:0] HOLD_MAX_STEPS = 7'h64;
    // Restore wait is programmed in minutes, nominally 5 to 12.
    localparam int unsigned RESTORE_MIN_DEFAULT = 5;
    localparam logic [3:0] RESTORE_RESET = 4'h5;
    // Switch completion bound.
    localparam int unsigned SWITCH_TIME_MS = 50;
    localparam int unsigned HOLD_STEP_CYCLES = HOLD_STEP_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned MINUTE_CYCLES = 60 * CLK_FREQ_HZ;
    // Data width of a connection point.
    localparam int unsigned DATA_W = 8;
    // Operation type encoding.
    localparam logic OPER_NONREVERT = 1'b0;
    localparam logic OPER_REVERT = 1'b1;
    // External commands.
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_CLEAR = 4'h1,
        CMD_BARRED = 4'h2,
        CMD_FORCE0 = 4'h3,
        CMD_FORCE1 = 4'h4,
        CMD_MANUAL0 = 4'h5,
        CMD_MANUAL1 = 4'h6,
        CMD_TRIAL0 = 4'h7,
        CMD_TRIAL1 = 4'h8,
        CMD_BARRED_OR_FORCE = 4'h9
    } ext_cmd_t;
    // Active request priority, lowest first.
    typedef enum logic [3:0] {
        REQ_NONE = 4'h0,
        REQ_RESTORE = 4'h1,
        REQ_TRIAL = 4'h2,
        REQ_MANUAL = 4'h3,
        REQ_DEGRADE = 4'h4,
        REQ_FAIL = 4'h5,
        REQ_FORCE = 4'h6,
        REQ_BARRED = 4'h7
    } req_t;
endpackage : prot_switch_pkg

/* tb/prot_switch_properties.sv */
// Port checker for the protection switch.
// Assumes binding to prot_switch, one clock domain.
`timescale 1ns/10ps
module prot_switch_properties (
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    input wire logic [prot_switch_pkg::DATA_W-1:0] i_norm_data,
    input wire logic i_work_server_signal_fail,
    input wire logic i_prot_server_signal_fail,
    input wire logic [6:0] i_switch_delay_time,
    input wire logic [3:0] i_external_command,
    input wire logic i_external_command_valid,
    input wire logic i_operation_type,
    input wire logic i_fail_report_enable,
    input wire logic [prot_switch_pkg::DATA_W-1:0] o_work_data,
    input wire logic [prot_switch_pkg::DATA_W-1:0] o_prot_data,
    input wire logic o_trail_fail_out,
    input wire logic o_fail_report_cause,
    input wire logic o_select_prot,
    input wire logic [3:0] o_active_request,
    input wire logic o_command_refused
);
    logic [2:0] up;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_SYS_RST);
    // Counts edges after reset so the bridge pipeline is full before it is judged.
    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            up <= 3'h0;
        end else if (up != 3'h7) begin
            up <= up + 3'h1;
        end
    end
    a_work_bridge: assert property (up == 3'h7 |-> o_work_data == $past(i_norm_data, 3))
        else $error("working output does not carry the normal input");
    a_prot_bridge: assert property (o_prot_data == o_work_data)
        else $error("protection output differs from working output");
    a_cause_gate: assert property (o_fail_report_cause == (o_trail_fail_out && i_fail_report_enable))
        else $error("fail report cause not gated by enable");
    a_refuse_once: assert property (o_command_refused |=> !o_command_refused)
        else $error("refusal pulse longer than one cycle");
    a_refuse_cause: assert property (i_external_command_valid && i_operation_type == prot_switch_pkg::OPER_REVERT
        && i_external_command == prot_switch_pkg::CMD_FORCE0 |=> o_command_refused)
        else $error("forced switch to path 0 accepted in revertive mode");
    a_force_select: assert property (i_external_command_valid && i_external_command == prot_switch_pkg::CMD_FORCE1
        && o_active_request != prot_switch_pkg::REQ_BARRED |-> ##[1:8] o_select_prot)
        else $error("forced switch to protection not carried out");
    a_barred_work: assert property (o_active_request == prot_switch_pkg::REQ_BARRED [*6] |-> !o_select_prot)
        else $error("protection selected while barred");
    a_fail_switch: assert property ((i_work_server_signal_fail && !i_prot_server_signal_fail
        && i_switch_delay_time == 7'h0 && o_active_request < prot_switch_pkg::REQ_FORCE) [*8] |-> o_select_prot)
        else $error("working fail did not select protection");
endmodule : prot_switch_properties
bind prot_switch prot_switch_properties chk (.I_CLOCK, .I_SYS_RST, .i_norm_data, .i_work_server_signal_fail,
    .i_prot_server_signal_fail, .i_switch_delay_time, .i_external_command, .i_external_command_valid,
    .i_operation_type, .i_fail_report_enable, .o_work_data, .o_prot_data, .o_trail_fail_out,
    .o_fail_report_cause, .o_select_prot, .o_active_request, .o_command_refused);

/* tb/peer_switch_model.sv */
// Far-end peer switch sending one bridged stream on both trails.
// Assumes run frames the link clock; the peer's own request comes from the bench.
`timescale 1ns/10ps
module peer_switch_model (
    input wire logic run,
    input wire logic [3:0] own_req,
    output logic [7:0] data = 8'h00,
    output logic lclk = 1'b0,
    output logic fs = 1'b0,
    output logic [3:0] req_out
);
    logic [3:0] pos = 4'h0;
    // The link clock stands still outside frames.
    always #62.5 if (run) lclk = ~lclk;
    // The same byte goes out on both trails, as the peer bridge does.
    always @(negedge lclk) begin
        data <= data + 8'h01;
        pos <= pos + 4'h1;
        fs <= (pos == 4'hf);
    end
    // The peer sends its own request; an echo of ours would hold itself up forever.
    assign req_out = own_req;
endmodule : peer_switch_model

/* tb/prot_switch_bench.sv */
// Self-checking bench for the protection switch.
// Assumes the peer model and bound checker; timers shortened by parameters.
`timescale 1ns/10ps
module prot_switch_bench;
    logic clk = 1'b0, rst = 1'b1, run = 1'b0, wf = 1'b0, wd = 1'b0, pf = 1'b0, pd = 1'b0;
    logic bi = 1'b0, oper = 1'b0, ven = 1'b0, rep = 1'b0;
    logic [3:0] cmd = 4'h0, rwt = 4'h5, pch, och, areq;
    logic [6:0] hot = 7'h0;
    logic [3:0] preq = 4'h0;
    logic [7:0] nd = 8'h00, ld, wdat, pdat;
    logic lclk, lfs, tf, cause, sel, refd, busy;
    int err_total = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    peer_switch_model peer (.run(run), .own_req(preq), .data(ld), .lclk(lclk), .fs(lfs), .req_out(pch));
    prot_switch #(.HOLD_STEP_CYC(10), .MINUTE_CYC(50)) uut (.I_CLOCK(clk), .I_SYS_RST(rst),
        .i_work_data(ld), .i_work_clk(lclk), .i_work_fs(lfs), .i_work_server_signal_fail(wf),
        .i_work_server_signal_degrade(wd), .i_prot_data(ld), .i_prot_clk(lclk), .i_prot_fs(lfs),
        .i_prot_server_signal_fail(pf), .i_prot_server_signal_degrade(pd), .i_switch_protocol_channel(pch),
        .i_norm_data(nd), .i_norm_clk(lclk), .i_norm_fs(lfs), .i_bidirectional(bi), .i_operation_type(oper),
        .i_restore_wait_time(rwt), .i_switch_delay_time(hot), .i_external_command(cmd),
        .i_external_command_valid(ven), .i_fail_report_enable(rep), .o_work_data(wdat), .o_work_clk(),
        .o_work_fs(), .o_prot_data(pdat), .o_prot_clk(), .o_prot_fs(), .o_switch_protocol_channel(och),
        .o_norm_data(), .o_norm_clk(), .o_norm_fs(), .o_trail_fail_out(tf), .o_fail_report_cause(cause),
        .o_select_prot(sel), .o_switch_busy(busy), .o_active_request(areq), .o_command_refused(refd));
    task automatic chk_bit(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit
    task automatic chk_vec(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_vec
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // Sends one command and reports whether a refusal pulse was seen.
    task automatic send(input logic [3:0] c, output logic seen);
        @(negedge clk);
        cmd = c;
        ven = 1'b1;
        @(negedge clk);
        ven = 1'b0;
        seen = refd;
        @(negedge clk);
        seen = seen | refd;
    endtask : send
    task automatic wait_sel(input logic exp, input int n);
        repeat (n) if (sel !== exp) @(negedge clk);
        chk_bit("select", exp, sel);
    endtask : wait_sel
    task automatic idle();
        repeat (400) if (busy !== 1'b0) @(negedge clk);
    endtask : idle
    function automatic logic legal(input logic rev, input logic b, input logic [3:0] c);
        if (c inside {4'h1, 4'h2, 4'h4, 4'h6}) return 1'b1;
        if (rev) return 1'b0;
        if (c inside {4'h3, 4'h5}) return 1'b1;
        return b && (c inside {4'h7, 4'h8, 4'h9});
    endfunction : legal
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    initial begin
        #300_000;
        err_total++;
        close_out();
    end
    initial begin
        logic seen;
        void'($urandom(32'hcbcee6d0));
        cyc(16);
        rst = 1'b0;
        run = 1'b1;
        repeat (8) begin
            nd = 8'($urandom);
            cyc(6);
            chk_vec("work out", nd, wdat);
            chk_vec("prot out", nd, pdat);
        end
        // Command codes 1 to 9 in revertive, uni non-revertive and bi non-revertive modes.
        for (int m = 0; m < 3; m++) begin
            idle();
            oper = (m == 0);
            bi = (m == 2);
            cyc(4);
            for (int c = 1; c < 10; c++) begin
                send(4'(c), seen);
                chk_bit("refused", !legal(oper, bi, 4'(c)), seen);
            end
            send(prot_switch_pkg::CMD_CLEAR, seen);
            cyc(10);
        end
        send(prot_switch_pkg::CMD_FORCE1, seen);
        wait_sel(1'b1, 20);
        chk_vec("channel", 8'(prot_switch_pkg::REQ_FORCE), 8'(och));
        send(prot_switch_pkg::CMD_FORCE0, seen);
        wait_sel(1'b0, 20);
        send(prot_switch_pkg::CMD_CLEAR, seen);
        bi = 1'b0;
        wf = 1'b1;
        wait_sel(1'b1, 20);
        chk_bit("trail fail", 1'b0, tf);
        pf = 1'b1;
        rep = 1'b1;
        cyc(10);
        chk_bit("trail fail", 1'b1, tf);
        chk_bit("cause", 1'b1, cause);
        rep = 1'b0;
        cyc(1);
        chk_bit("cause", 1'b0, cause);
        pf = 1'b0;
        send(prot_switch_pkg::CMD_BARRED, seen);
        cyc(20);
        chk_bit("barred", 1'b0, sel);
        wf = 1'b0;
        send(prot_switch_pkg::CMD_CLEAR, seen);
        wd = 1'b1;
        wait_sel(1'b1, 20);
        wd = 1'b0;
        send(prot_switch_pkg::CMD_FORCE0, seen);
        wait_sel(1'b0, 20);
        send(prot_switch_pkg::CMD_CLEAR, seen);
        idle();
        bi = 1'b1;
        cyc(4);
        preq = 4'(prot_switch_pkg::REQ_FAIL);
        wait_sel(1'b1, 20);
        preq = 4'h0;
        send(prot_switch_pkg::CMD_FORCE0, seen);
        wait_sel(1'b0, 20);
        send(prot_switch_pkg::CMD_CLEAR, seen);
        bi = 1'b0;
        idle();
        oper = 1'b1;
        hot = 7'h02;
        cyc(4);
        wf = 1'b1;
        cyc(12);
        chk_bit("hold-off", 1'b0, sel);
        wait_sel(1'b1, 40);
        wf = 1'b0;
        cyc(200);
        chk_bit("restore wait", 1'b1, sel);
        wait_sel(1'b0, 100);
        close_out();
    end
endmodule : prot_switch_bench
